// [hdl/ast_baud.sv]
// Baud divider giving one tick per oversampling slot
`timescale 1ns/1ps
module ast_baud import ast_pkg::*; #(
  parameter int DIV_W = AST_DIV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divisor and tick
  input wire logic [DIV_W-1:0] divisor,
  output logic os_tick
);

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
      $error("ast_baud: DIV_W must lie in 1..16");
    end
  endgenerate

  logic [DIV_W-1:0] cnt_ff;
  logic tick_ff;
  wire cnt_zero = (cnt_ff == '0);
  wire [DIV_W-1:0] nxt_cnt = cnt_zero ? divisor : cnt_ff - 1'b1;

  // Period is divisor+1 clocks, so one bit spans 16*(divisor+1) clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= cnt_zero;
    end
  end

  assign os_tick = tick_ff;

endmodule : ast_baud

// [hdl/ast_transceiver.sv]
// Full-duplex asynchronous serial transceiver with port pin takeover
`timescale 1ns/1ps
// Contract
// - Enabled idle transmitter loads written character at once
// - Busy transmitter loads after current stop bit
// - Every load without a same-cycle write sets transmit buffer empty
// - Frame: start low, data, ninth, stop high
// - Start bit on first tick after load
// - Empty flag stays until next write
// - Transmit done after stop held one bit, only when no character is pending
// - Transmitter enable forces transmit pin output
// - Receiver samples sixteen times per bit
// - Start rejected if samples 8-10 mostly high
// - Data bit is majority of 8-10
// - Mostly low stop sets framing error
// - Every character not discarded or ignored moves to buffer, sets done
// - Reads return receive, writes load transmit
// - Ninth received bit captured in nine-bit mode
// - Unread buffer: discard, buffered overrun flag
// - Receiver enable forces receive pin input
// - Multidrop slave accepts only address-marked bytes
// - Baud is clock over 16*(divisor+1)
// - Address marked by ninth or stop bit
// - Multidrop ignores data bytes entirely
// - Reading receive buffer clears done flag
module ast_transceiver import ast_pkg::*; #(
  parameter int DIV_W = AST_DIV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control bits and baud divisor
  input wire ast_ctrl_t ctrl,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic tx_done_clr,
  // Shared data port
  input wire logic data_wr,
  input wire logic [7:0] data_wr_val,
  input wire logic data_rd,
  output logic [7:0] serial_data_port,
  // Status
  output ast_status_t status,
  // General port settings for both pins
  input wire logic dir_bit_pin_zero,
  input wire logic dir_bit_pin_one,
  input wire logic port_d_out_bit_zero,
  input wire logic port_d_out_bit_one,
  // Receive pin
  input wire logic port_d_pin_zero_i,
  output logic port_d_pin_zero_o,
  output logic port_d_pin_zero_oe,
  output logic port_d_pin_zero_pullup,
  // Transmit pin
  output logic port_d_pin_one_o,
  output logic port_d_pin_one_oe
);

  generate
    if (DIV_W != AST_DIV_W) begin : g_bad_div
      $error("ast_transceiver: divisor width must be 12");
    end
  endgenerate

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  // Oversampling tick and bit tick
  logic os_tick;
  logic [3:0] tx_phase_ff;

  ast_baud #(.DIV_W(DIV_W)) u_baud (
    .clk(clk),
    .rst(rst),
    .divisor(baud_divisor),
    .os_tick(os_tick)
  );

  wire bit_tick = os_tick && (tx_phase_ff == AST_OS_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) tx_phase_ff <= 4'h0;
    else if (os_tick) tx_phase_ff <= tx_phase_ff + 4'h1;
  end

  // Transmit side
  ast_tx_state_t tx_state_ff;
  logic [7:0] tx_hold_ff;
  logic tx_hold_ninth_ff;
  logic tx_full_ff;
  logic [AST_FRAME_W-1:0] tx_sr_ff;
  logic [3:0] tx_cnt_ff;
  logic txd_ff;
  logic tx_done_ff;

  wire tx_stop_done = (tx_state_ff == AST_TX_SEND) && bit_tick && (tx_cnt_ff == 4'h0);
  wire tx_can_load = (tx_state_ff == AST_TX_IDLE) || tx_stop_done;
  logic tx_active_ff;
  // Disabling mid-frame still lets the shifter and the pending character go out,
  // but a write to a disabled idle transmitter waits for the enable
  wire tx_busy = (tx_state_ff != AST_TX_IDLE) || tx_full_ff;
  wire tx_run = ctrl.transmitter_on || (tx_active_ff && tx_busy);
  wire tx_load = tx_full_ff && tx_can_load && tx_run;
  wire tx_ninth = ctrl.nine_bit_select ? tx_hold_ninth_ff : 1'b1;
  wire [AST_FRAME_W-1:0] tx_frame = {1'b1, tx_ninth, tx_hold_ff, 1'b0};
  wire [3:0] tx_len = ctrl.nine_bit_select ? AST_LEN_9 : AST_LEN_8;
  wire tx_set_done = tx_stop_done && !tx_full_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) tx_active_ff <= 1'b0;
    else tx_active_ff <= tx_run;
  end

  // Transmit holding register; a write in the load cycle wins the buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_hold_ff <= 8'h00;
      tx_hold_ninth_ff <= 1'b0;
      tx_full_ff <= ~AST_RST_TX_EMPTY;
    end else if (data_wr) begin
      tx_hold_ff <= data_wr_val;
      tx_hold_ninth_ff <= ctrl.tx_ninth_bit;
      tx_full_ff <= 1'b1;
    end else if (tx_load) begin
      tx_full_ff <= 1'b0;
    end
  end

  // Transmit shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state_ff <= AST_TX_IDLE;
      tx_sr_ff <= '1;
      tx_cnt_ff <= 4'h0;
      txd_ff <= AST_RST_LINE;
    end else begin
      case (tx_state_ff)
        AST_TX_IDLE: begin
          txd_ff <= 1'b1;
          if (tx_load) begin
            tx_sr_ff <= tx_frame;
            tx_cnt_ff <= tx_len - 4'h1;
            tx_state_ff <= AST_TX_WAIT;
          end
        end
        AST_TX_WAIT: begin
          if (bit_tick) begin
            txd_ff <= tx_sr_ff[0];
            tx_sr_ff <= {1'b1, tx_sr_ff[AST_FRAME_W-1:1]};
            tx_state_ff <= AST_TX_SEND;
          end
        end
        AST_TX_SEND: begin
          if (bit_tick) begin
            if (tx_cnt_ff != 4'h0) begin
              txd_ff <= tx_sr_ff[0];
              tx_sr_ff <= {1'b1, tx_sr_ff[AST_FRAME_W-1:1]};
              tx_cnt_ff <= tx_cnt_ff - 4'h1;
            end else if (tx_load) begin
              tx_sr_ff <= tx_frame;
              tx_cnt_ff <= tx_len - 4'h1;
              tx_state_ff <= AST_TX_WAIT;
            end else begin
              tx_state_ff <= AST_TX_IDLE;
            end
          end
        end
        default: tx_state_ff <= AST_TX_IDLE;
      endcase
    end
  end

  // Transmit done: the hardware set beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tx_done_ff <= 1'b0;
    else if (tx_set_done) tx_done_ff <= 1'b1;
    else if (tx_done_clr) tx_done_ff <= 1'b0;
  end

  // Receive pin synchroniser
  logic rx_meta_ff;
  logic rxd_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta_ff <= AST_RST_LINE;
      rxd_ff <= AST_RST_LINE;
    end else begin
      rx_meta_ff <= port_d_pin_zero_i;
      rxd_ff <= rx_meta_ff;
    end
  end

  // Receive side
  ast_rx_state_t rx_state_ff;
  logic [3:0] rx_smp_ff;
  logic [3:0] rx_idx_ff;
  logic rx_va_ff;
  logic rx_vb_ff;
  logic [8:0] rx_sr_ff;
  logic [7:0] rx_buf_ff;
  logic rx_ninth_ff;
  logic rx_done_ff;
  logic fe_ff;
  logic or_ff;
  logic or_pend_ff;

  wire rx_vote = maj3(rx_va_ff, rx_vb_ff, rxd_ff);
  wire rx_decide = os_tick && (rx_smp_ff == AST_SMP_C);
  wire [3:0] rx_dbits = ctrl.nine_bit_select ? AST_DBITS_9 : AST_DBITS_8;
  wire rx_end = (rx_state_ff == AST_RX_STOP) && rx_decide;
  wire rx_stop_ok = rx_vote;
  wire rx_marker = ctrl.nine_bit_select ? rx_sr_ff[AST_NINTH_POS] : rx_stop_ok;
  wire rx_ignore = ctrl.multidrop_mode && !rx_marker;
  // A read in the same cycle frees the buffer, so no false overrun
  wire rx_buf_free = !rx_done_ff || data_rd;
  wire rx_move = rx_end && !rx_ignore && rx_buf_free;
  wire rx_lost = rx_end && !rx_ignore && !rx_buf_free;

  // Sample counter runs 1..16 per bit from the first low sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_ff <= AST_RX_IDLE;
      rx_smp_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_va_ff <= 1'b1;
      rx_vb_ff <= 1'b1;
      rx_sr_ff <= 9'h000;
    end else if (!ctrl.receiver_on) begin
      rx_state_ff <= AST_RX_IDLE;
    end else if (os_tick) begin
      rx_smp_ff <= rx_smp_ff + 4'h1;
      if (rx_smp_ff == AST_SMP_A) rx_va_ff <= rxd_ff;
      if (rx_smp_ff == AST_SMP_B) rx_vb_ff <= rxd_ff;
      case (rx_state_ff)
        AST_RX_IDLE: begin
          if (!rxd_ff) begin
            rx_smp_ff <= AST_SMP_START + 4'h1;
            rx_state_ff <= AST_RX_START;
          end
        end
        AST_RX_START: begin
          if (rx_smp_ff == AST_SMP_C) begin
            rx_idx_ff <= 4'h0;
            rx_sr_ff <= 9'h000;
            if (rx_vote) rx_state_ff <= AST_RX_IDLE;
            else rx_state_ff <= AST_RX_DATA;
          end
        end
        AST_RX_DATA: begin
          if (rx_smp_ff == AST_SMP_C) begin
            rx_sr_ff[rx_idx_ff] <= rx_vote;
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff == rx_dbits - 4'h1) rx_state_ff <= AST_RX_STOP;
          end
        end
        AST_RX_STOP: begin
          // Ending at mid stop bit leaves time to catch the next start edge
          if (rx_smp_ff == AST_SMP_C) rx_state_ff <= AST_RX_IDLE;
        end
        default: rx_state_ff <= AST_RX_IDLE;
      endcase
    end
  end

  // Receive buffer and its flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buf_ff <= 8'h00;
      rx_ninth_ff <= AST_RST_RX_NINTH;
      fe_ff <= 1'b0;
    end else if (rx_move) begin
      rx_buf_ff <= rx_sr_ff[7:0];
      fe_ff <= !rx_stop_ok;
      if (ctrl.nine_bit_select) rx_ninth_ff <= rx_sr_ff[AST_NINTH_POS];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) rx_done_ff <= 1'b0;
    else if (rx_move) rx_done_ff <= 1'b1;
    else if (data_rd) rx_done_ff <= 1'b0;
  end

  // Overrun waits behind the unread byte and shows once it is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      or_ff <= 1'b0;
      or_pend_ff <= 1'b0;
    end else begin
      if (rx_lost) or_pend_ff <= 1'b1;
      else if (data_rd) or_pend_ff <= 1'b0;
      if (rx_move) or_ff <= 1'b0;
      else if (data_rd) or_ff <= or_pend_ff || rx_lost;
    end
  end

  // Register side outputs
  assign serial_data_port = rx_buf_ff;
  assign status.rx_done_flag = rx_done_ff;
  assign status.tx_done_flag = tx_done_ff;
  assign status.tx_buffer_empty = !tx_full_ff;
  assign status.frame_error_flag = fe_ff;
  assign status.overrun_flag = or_ff;
  assign status.rx_ninth_bit = rx_ninth_ff;

  // Pin takeover
  assign port_d_pin_zero_oe = ctrl.receiver_on ? 1'b0 : dir_bit_pin_zero;
  assign port_d_pin_zero_o = port_d_out_bit_zero;
  assign port_d_pin_zero_pullup = !port_d_pin_zero_oe && port_d_out_bit_zero;
  assign port_d_pin_one_oe = tx_run || dir_bit_pin_one;
  assign port_d_pin_one_o = tx_run ? txd_ff : port_d_out_bit_one;

endmodule : ast_transceiver

// [shared/ast_pkg.sv]
// Shared constants, states and carriers of the asynchronous serial transceiver
package ast_pkg;

  // Baud divider and oversampling
  localparam int AST_DIV_W = 12;
  localparam int AST_DIV_MAX = 4095;
  localparam logic [3:0] AST_OS_LAST = 4'hf;
  localparam logic [3:0] AST_SMP_START = 4'h1;
  localparam logic [3:0] AST_SMP_A = 4'h8;
  localparam logic [3:0] AST_SMP_B = 4'h9;
  localparam logic [3:0] AST_SMP_C = 4'ha;

  // Frame layout
  localparam int AST_FRAME_W = 11;
  localparam logic [3:0] AST_LEN_8 = 4'ha;
  localparam logic [3:0] AST_LEN_9 = 4'hb;
  localparam logic [3:0] AST_DBITS_8 = 4'h8;
  localparam logic [3:0] AST_DBITS_9 = 4'h9;
  localparam int AST_NINTH_POS = 8;

  // Reset values
  localparam logic AST_RST_LINE = 1'b1;
  localparam logic AST_RST_TX_EMPTY = 1'b1;
  localparam logic AST_RST_RX_NINTH = 1'b1;

  typedef enum logic [1:0] {
    AST_TX_IDLE = 2'b00,
    AST_TX_WAIT = 2'b01,
    AST_TX_SEND = 2'b11
  } ast_tx_state_t;

  typedef enum logic [1:0] {
    AST_RX_IDLE = 2'b00,
    AST_RX_START = 2'b01,
    AST_RX_DATA = 2'b11,
    AST_RX_STOP = 2'b10
  } ast_rx_state_t;

  typedef struct packed {
    logic transmitter_on;
    logic receiver_on;
    logic nine_bit_select;
    logic tx_ninth_bit;
    logic multidrop_mode;
  } ast_ctrl_t;

  typedef struct packed {
    logic rx_done_flag;
    logic tx_done_flag;
    logic tx_buffer_empty;
    logic frame_error_flag;
    logic overrun_flag;
    logic rx_ninth_bit;
  } ast_status_t;

endpackage : ast_pkg

// [tb/ast_remote_node.sv]
// Remote serial node: frame source and frame sink
`timescale 1ns/1ps
module ast_remote_node (
  // Clock, bit time and character size
  input wire logic clk,
  input wire logic [31:0] bt,
  input wire logic nine,
  // Serial lines
  output logic rxd,
  input wire logic txd,
  // Decoded frame: stop, ninth, data
  output logic [9:0] got,
  output logic got_stb
);
  logic [9:0] s;
  initial begin
    rxd = 1'b1;
    got_stb = 1'b0;
    got = 10'h000;
  end
  // An 8-bit frame is padded with one idle bit, so every frame is 11 bit times
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (bt) @(negedge clk);
    end
    rxd = 1'b1;
  endtask : send
  task automatic glitch(input int n);
    @(negedge clk);
    rxd = 1'b0;
    repeat (n) @(negedge clk);
    rxd = 1'b1;
  endtask : glitch
  always begin : sink
    @(negedge txd);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (bt) @(posedge clk);
      s[i] = txd;
    end
    got = nine ? s : {s[8], 1'b0, s[7:0]};
    got_stb = 1'b1;
    @(posedge clk);
    got_stb = 1'b0;
  end
endmodule : ast_remote_node

// [tb/ast_transceiver_properties.sv]
// Port assertions for the serial transceiver
`timescale 1ns/1ps
module ast_transceiver_properties import ast_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire ast_ctrl_t ctrl,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic port_d_out_bit_zero,
  input wire logic [7:0] serial_data_port,
  input wire ast_status_t status,
  input wire logic port_d_pin_zero_oe,
  input wire logic port_d_pin_zero_pullup,
  input wire logic port_d_pin_one_o,
  input wire logic port_d_pin_one_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shifter surely idle: done rose and nothing written since
  logic idle_ff;
  logic done_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      idle_ff <= ~data_wr & (idle_ff | (status.tx_done_flag & ~done_ff));
      done_ff <= status.tx_done_flag;
    end
  end
  a_tx_pin_driven: assert property (ctrl.transmitter_on |-> port_d_pin_one_oe)
    else $error("tx pin released");
  a_rx_pin_input: assert property (ctrl.receiver_on |-> !port_d_pin_zero_oe &&
    port_d_pin_zero_pullup == port_d_out_bit_zero) else $error("rx pin driven");
  a_write_fills: assert property (data_wr && status.tx_buffer_empty |=>
    !status.tx_buffer_empty) else $error("write lost");
  a_empty_holds: assert property (status.tx_buffer_empty && !data_wr |=>
    status.tx_buffer_empty) else $error("empty dropped");
  a_idle_load: assert property (data_wr && idle_ff && ctrl.transmitter_on |=>
    !status.tx_buffer_empty ##1 status.tx_buffer_empty) else $error("no load");
  a_done_line: assert property ($rose(status.tx_done_flag) |-> port_d_pin_one_o &&
    $past(port_d_pin_one_o, 2) && status.tx_buffer_empty) else $error("early done");
  a_port_moves: assert property ($changed(serial_data_port) |-> status.rx_done_flag)
    else $error("silent move");
  a_ovr_on_read: assert property ($rose(status.overrun_flag) |-> $past(data_rd))
    else $error("overrun early");
  c_ovr: cover property ($rose(status.overrun_flag));
  c_fe: cover property ($rose(status.frame_error_flag));
  c_done: cover property ($rose(status.tx_done_flag));
endmodule : ast_transceiver_properties

bind ast_transceiver ast_transceiver_properties u_props (.clk, .rst, .ctrl, .data_wr,
  .data_rd, .port_d_out_bit_zero, .serial_data_port, .status, .port_d_pin_zero_oe,
  .port_d_pin_zero_pullup, .port_d_pin_one_o, .port_d_pin_one_oe);

// [tb/test_ast_transceiver.sv]
// Bench: transceiver against a remote node, with queued expectations
`timescale 1ns/1ps
module test_ast_transceiver import ast_pkg::*; ();
  localparam int BT = 32;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ast_ctrl_t ctrl = '0;
  logic clr = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wval = 8'h00;
  logic [3:0] pb = 4'h8;
  logic done_q = 1'b0;
  logic [31:0] seed = 32'h00013171;
  logic [7:0] rbuf;
  ast_status_t st;
  logic p0o, p0oe, p0pu, p1o, p1oe, rxd, stb;
  logic [9:0] got;
  logic [10:0] txq[$];
  logic [10:0] rxq[$];
  int fails = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  ast_transceiver DUT (.clk(clk), .rst(rst), .ctrl(ctrl), .baud_divisor(12'h001),
    .tx_done_clr(clr), .data_wr(wr), .data_wr_val(wval), .data_rd(rd),
    .serial_data_port(rbuf), .status(st), .dir_bit_pin_zero(pb[0]),
    .dir_bit_pin_one(pb[1]), .port_d_out_bit_zero(pb[2]), .port_d_out_bit_one(pb[3]),
    .port_d_pin_zero_i(p0oe ? p0o : rxd), .port_d_pin_zero_o(p0o),
    .port_d_pin_zero_oe(p0oe), .port_d_pin_zero_pullup(p0pu),
    .port_d_pin_one_o(p1o), .port_d_pin_one_oe(p1oe));
  // A released transmit line rests high on its pull-up
  ast_remote_node node (.clk(clk), .bt(BT), .nine(ctrl.nine_bit_select), .rxd(rxd),
    .txd(p1oe ? p1o : 1'b1), .got(got), .got_stb(stb));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic wr_byte(input logic [7:0] d, input logic n9);
    @(negedge clk);
    ctrl.tx_ninth_bit = n9;
    txq.push_back({2'b01, ctrl.nine_bit_select & n9, d});
    @(negedge clk);
    wval = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_byte
  task automatic rd_byte();
    @(negedge clk);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    cmp(16'(st.rx_done_flag), 16'h0000);
  endtask : rd_byte
  task automatic rx_frame(input logic [8:0] d, input logic stop, input logic keep);
    if (keep) rxq.push_back({ctrl.nine_bit_select, ~stop, d[8] & ctrl.nine_bit_select, d[7:0]});
    node.send(d, stop);
  endtask : rx_frame
  always @(posedge stb) cmp(16'(got), 16'(txq.size() ? txq.pop_front() : 11'h7ff));
  always @(negedge clk) begin : rx_watch
    logic [10:0] e;
    if (!rst && st.rx_done_flag && !done_q) begin
      e = rxq.size() ? rxq.pop_front() : 11'h7ff;
      cmp(16'({e[10], st.frame_error_flag, st.rx_ninth_bit & e[10], rbuf}), 16'(e));
    end
    done_q = st.rx_done_flag;
  end
  initial begin : main
    logic [7:0] a;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    cmp({2'b01, st, rbuf}, 16'h4900);
    // Out bit one kept high so the remote sink never sees a false start
    for (int i = 0; i < 32; i++) begin
      pb = 4'(xs()) | 4'h8;
      ctrl.transmitter_on = i[4];
      ctrl.receiver_on = i[4];
      @(negedge clk);
      cmp(16'({p0oe, p0pu, p1oe, p1o, p0o}),
        16'({~i[4] & pb[0], ~(~i[4] & pb[0]) & pb[2], i[4] | pb[1], 1'b1, pb[2]}));
    end
    for (int n = 0; n < 2; n++) begin
      ctrl.nine_bit_select = n[0];
      wr_byte(8'(xs()), 1'b1);
      wr_byte(8'(xs()), 1'b0);
      cmp(16'(st.tx_buffer_empty), 16'h0000);
      for (int k = 0; k <= 2000; k++) begin
        if (st.tx_done_flag === 1'b1) break;
        if (k == 2000) begin
          fails++;
          wrap_up();
        end
        @(negedge clk);
      end
      cmp(16'({st.tx_done_flag, st.tx_buffer_empty}), 16'h0003);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      cmp(16'(st.tx_done_flag), 16'h0000);
    end
    a = 8'(xs());
    rx_frame({1'b1, a}, 1'b1, 1'b1);
    rx_frame(9'(xs()), 1'b1, 1'b0);
    cmp(16'(rbuf), 16'(a));
    rd_byte();
    cmp(16'(st.overrun_flag), 16'h0001);
    ctrl.multidrop_mode = 1'b1;
    rx_frame({1'b0, 8'(xs())}, 1'b1, 1'b0);
    rx_frame({1'b1, 8'(xs())}, 1'b1, 1'b1);
    rd_byte();
    ctrl.nine_bit_select = 1'b0;
    rx_frame({1'b0, 8'(xs())}, 1'b0, 1'b0);
    rx_frame({1'b0, 8'(xs())}, 1'b1, 1'b1);
    rd_byte();
    ctrl.multidrop_mode = 1'b0;
    rx_frame({1'b0, 8'(xs())}, 1'b0, 1'b1);
    rd_byte();
    node.glitch(3);
    // Long enough for a wrongly accepted start to finish a whole character
    repeat (BT * 12) @(negedge clk);
    cmp(16'(st.rx_done_flag), 16'h0000);
    repeat (4) begin
      rx_frame({1'b0, 8'(xs())}, 1'b1, 1'b1);
      rd_byte();
    end
    repeat (BT) @(negedge clk);
    cmp(16'(txq.size() + rxq.size()), 16'h0000);
    wrap_up();
  end
endmodule : test_ast_transceiver
